// File: bench/afr_ctrl_model.sv
// Controller model that receives the words sent with each data transfer.
`timescale 1ns/100ps

module afr_ctrl_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic xfer_valid,
    input wire afr_pkg::afr_words_s xfer_words,
    output logic [15:0] rx_count,
    output afr_pkg::afr_words_s rx_words
);
    // Takes one copy of the words on every transfer pulse.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_count <= 16'h0000;
            rx_words <= '0;
        end else if (xfer_valid) begin
            rx_count <= rx_count + 16'h0001;
            rx_words <= xfer_words;
        end
    end
endmodule : afr_ctrl_model

// File: bench/tb.sv
// Self-checking bench of the fault and status word builder.
`timescale 1ns/100ps

module tb;
    logic ref_clk;
    logic reset;
    afr_pkg::afr_chan_s [15:0] chan_in;
    logic [15:0] chan_calibrating;
    logic big_variant;
    logic float_mode;
    afr_pkg::afr_wiring_e wiring;
    logic link_fault;
    logic xfer_req;
    logic xfer_valid;
    afr_pkg::afr_words_s xfer_words;
    afr_pkg::afr_words_s live_words;
    logic [15:0] rx_count;
    afr_pkg::afr_words_s rx_words;
    afr_pkg::afr_words_s exp_w;
    logic [15:0] base;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;

    afr_fault_report i_afr_fault_report (.ref_clk(ref_clk), .reset(reset),
        .chan_in(chan_in), .chan_calibrating(chan_calibrating),
        .big_variant(big_variant), .float_mode(float_mode),
        .wiring(wiring), .link_fault(link_fault), .xfer_req(xfer_req),
        .xfer_valid(xfer_valid), .xfer_words(xfer_words),
        .live_words(live_words));

    afr_ctrl_model i_afr_ctrl_model (.ref_clk(ref_clk), .reset(reset),
        .xfer_valid(xfer_valid), .xfer_words(xfer_words),
        .rx_count(rx_count), .rx_words(rx_words));

    ////////////////////////////////////////////////////////////////////////
    // Works out the expected words from the inputs now applied.
    function automatic afr_pkg::afr_words_s expect_w();
        afr_pkg::afr_words_s w;
        logic [15:0] used;
        logic [15:0] rng;
        logic trim;
        logic cal;
        case (wiring)
            afr_pkg::AFR_WIRE_SE: used = big_variant ? 16'hffff : 16'h00ff;
            afr_pkg::AFR_WIRE_DIFF: used = big_variant ? 16'h00ff : 16'h000f;
            afr_pkg::AFR_WIRE_HS: used = big_variant ? 16'h000f : 16'h0003;
            default: used = 16'h0000;
        endcase
        w = '0;
        rng = 16'h0000;
        trim = 1'b0;
        for (int k = 0; k < 16; k++) begin
            if (used[k]) begin
                rng[k] = chan_in[k].range_low_flag
                    | chan_in[k].range_high_flag;
                trim = trim | chan_in[k].channel_trim_error;
                if (float_mode) begin
                    w.channel_condition_word[k] = {
                        chan_in[k].channel_trim_error,
                        chan_in[k].range_low_flag,
                        chan_in[k].range_high_flag,
                        chan_in[k].slope_limit_flag,
                        chan_in[k].lower_limit_flag,
                        chan_in[k].upper_limit_flag,
                        chan_in[k].lower_lower_limit_flag,
                        chan_in[k].upper_upper_limit_flag};
                end else begin
                    w.packed_range_condition_word[31 - 2 * k] =
                        chan_in[k].range_low_flag;
                    w.packed_range_condition_word[30 - 2 * k] =
                        chan_in[k].range_high_flag;
                end
            end
        end
        cal = |(chan_calibrating & used);
        w.channel_summary_word = link_fault ? 16'hffff : (cal ? used : rng);
        w.module_summary_word[15] = |w.channel_summary_word;
        w.module_summary_word[10] = cal;
        w.module_summary_word[9] = trim;
        return w;
    endfunction : expect_w

    task automatic check(input logic [191:0] got, input logic [191:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %h expected %h", $time,
                got, exp);
        end
    endtask : check

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask : step

    task automatic finish_test();
        if (errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // Applies one set of conditions, checks live words and one transfer.
    task automatic run(input logic big, input logic flt,
            input afr_pkg::afr_wiring_e wir, input logic link,
            input logic [15:0] cal, input int ch, input logic [7:0] flags);
        big_variant = big;
        float_mode = flt;
        wiring = wir;
        link_fault = link;
        chan_calibrating = cal;
        chan_in = '0;
        chan_in[ch] = flags;
        step();
        step();
        exp_w = expect_w();
        check(live_words, exp_w);
        xfer_req = 1'b1;
        step();
        xfer_req = 1'b0;
        check(192'(xfer_valid), 192'h1);
        check(xfer_words, exp_w);
        step();
        check(192'(xfer_valid), 192'h0);
        check(rx_words, exp_w);
    endtask : run

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        reset = 1'b1;
        xfer_req = 1'b0;
        chan_in = '0;
        chan_calibrating = 16'h0000;
        big_variant = 1'b1;
        float_mode = 1'b0;
        wiring = afr_pkg::AFR_WIRE_SE;
        link_fault = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        run(1, 0, afr_pkg::AFR_WIRE_SE, 0, 16'h0000, 0, 8'h40);
        run(1, 0, afr_pkg::AFR_WIRE_SE, 0, 16'h0000, 15, 8'h20);
        run(1, 0, afr_pkg::AFR_WIRE_SE, 0, 16'h0000, 7,
            8'hff);
        run(1, 0, afr_pkg::AFR_WIRE_DIFF, 0, 16'h0000, 6, 8'h60);
        run(1, 1, afr_pkg::AFR_WIRE_SE, 0, 16'h0000, 5, 8'h5a);
        run(1, 1, afr_pkg::AFR_WIRE_SE, 0, 16'h0000, 9, 8'h80);
        run(1, 0, afr_pkg::AFR_WIRE_HS, 0, 16'h0000, 4, 8'h40);
        run(0, 1, afr_pkg::AFR_WIRE_SE, 0, 16'h0000, 9, 8'h40);
        run(0, 1, afr_pkg::AFR_WIRE_HS, 0, 16'h0004, 1, 8'h00);
        for (int w = 0; w < 3; w++) begin
            for (int b = 0; b < 2; b++) begin
                run(1'(b), 1, afr_pkg::afr_wiring_e'(w), 0, 16'h0001, 0,
                    8'h40);
            end
        end
        run(0, 1, afr_pkg::AFR_WIRE_DIFF, 1, 16'h0001, 0,
            8'h40);
        run(1, 0, afr_pkg::AFR_WIRE_HS, 1, 16'h0000, 0, 8'h00);
        run(1, 0, afr_pkg::afr_wiring_e'(3), 0, 16'h0001, 2,
            8'h60);
        base = rx_count;
        xfer_req = 1'b1;
        step();
        step();
        step();
        xfer_req = 1'b0;
        check(192'(xfer_valid), 192'h1);
        step();
        check(192'(rx_count - base), 192'h3);
        check(192'(xfer_valid), 192'h0);
        reset = 1'b1;
        #10;
        check(live_words, 192'h0);
        check(192'(xfer_valid), 192'h0);
        step();
        reset = 1'b0;
        run(1, 0, afr_pkg::AFR_WIRE_SE, 0, 16'h0000, 3, 8'h40);
        finish_test();
    end
endmodule : tb

// File: design/afr_cond_word.sv
// One channel's condition word and its range and trim summary terms.
`timescale 1ns/100ps

module afr_cond_word (
    input wire afr_pkg::afr_chan_s chan,
    input wire logic used,
    input wire logic float_mode,
    output logic [7:0] cond_word,
    output logic range_low,
    output logic range_high,
    output logic trim_hit
);

    ////////////////////////////////////////////////////////////////////////
    // Full word only in floating point mode, nothing in integer mode.
    always_comb begin
        if (used && float_mode) begin
            cond_word = chan;
        end else begin
            cond_word = afr_pkg::COND_RST;
        end
    end

    // Range flags feed the packed word and the channel summary.
    assign range_low = used & chan.range_low_flag;
    assign range_high = used & chan.range_high_flag;

    // A badly trimmed channel counts in both modes.
    assign trim_hit = used & chan.channel_trim_error;

endmodule : afr_cond_word

// File: design/afr_fault_report.sv
// Fault and status word builder with a snapshot per data transfer.
`timescale 1ns/100ps

// Functional notes
// - Integer mode: only range flags per channel.
// - Integer mode: one 32-bit packed range word.
// - Low flags on odd bits, channel 0 bit 31.
// - High flags on even bits, channel 0 bit 30.
// - Low range sets flag and summary bit.
// - High range sets flag and summary bit.
// - Channel trim error sets module bit 9.
// - Integer mode still raises module trim error.
// - Words sent with every data transfer.
// - Small variant uses 8, 4, 2 channels.
// - Float mode: one condition word per channel.
// - Module word nonzero on any fault.
// - Group flag set by any summary bit.
// - Calibrating sets flag and used summary bits.
// - Any channel trim error sets module flag.
// - Range condition sets channel summary bit.
// - Calibration pattern ffff, 00ff, 000f or 0003.
// - Link fault forces summary to ffff.
// - Module word bits 15, 10, 9 used.
// - Condition word bit order trim down to alarms.
module afr_fault_report (
    input wire logic ref_clk,
    input wire logic reset,
    input wire afr_pkg::afr_chan_s [15:0] chan_in,
    input wire logic [15:0] chan_calibrating,
    input wire logic big_variant,
    input wire logic float_mode,
    input wire afr_pkg::afr_wiring_e wiring,
    input wire logic link_fault,
    input wire logic xfer_req,
    output logic xfer_valid,
    output afr_pkg::afr_words_s xfer_words,
    output afr_pkg::afr_words_s live_words
);

    ////////////////////////////////////////////////////////////////////////
    afr_pkg::afr_state_s s_q;
    afr_pkg::afr_state_s s_d;
    logic [15:0] used_mask;
    logic [15:0] low_vec;
    logic [15:0] high_vec;
    logic [15:0] trim_vec;
    logic [15:0][7:0] cond_vec;
    logic any_cal;
    logic [15:0] sum_c;
    logic [15:0] mod_c;
    logic [31:0] pack_c;

    ////////////////////////////////////////////////////////////////////////
    // Channels in use depend on the variant and the wiring.
    always_comb begin
        unique case (wiring)
            afr_pkg::AFR_WIRE_SE: begin
                used_mask = big_variant ? afr_pkg::MASK_BIG_SE
                                        : afr_pkg::MASK_SMALL_SE;
            end
            afr_pkg::AFR_WIRE_DIFF: begin
                used_mask = big_variant ? afr_pkg::MASK_BIG_DIFF
                                        : afr_pkg::MASK_SMALL_DIFF;
            end
            afr_pkg::AFR_WIRE_HS: begin
                used_mask = big_variant ? afr_pkg::MASK_BIG_HS
                                        : afr_pkg::MASK_SMALL_HS;
            end
            default: begin
                used_mask = afr_pkg::SUM_RST;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // One condition builder per channel.
    for (genvar i = 0; i < afr_pkg::NUM_CH; i++) begin : g_ch
        afr_cond_word u_cond (
            .chan(chan_in[i]),
            .used(used_mask[i]),
            .float_mode(float_mode),
            .cond_word(cond_vec[i]),
            .range_low(low_vec[i]),
            .range_high(high_vec[i]),
            .trim_hit(trim_vec[i])
        );
    end

    assign any_cal = |(chan_calibrating & used_mask);

    ////////////////////////////////////////////////////////////////////////
    // Channel summary, module summary and packed range word.
    always_comb begin
        if (link_fault) begin
            sum_c = afr_pkg::COMM_FAULT_PATTERN;
        end else if (any_cal) begin
            sum_c = used_mask;
        end else begin
            sum_c = low_vec | high_vec;
        end
        mod_c = afr_pkg::SUM_RST;
        mod_c[afr_pkg::MOD_GROUP_BIT] = |sum_c;
        mod_c[afr_pkg::MOD_CAL_BIT] = any_cal;
        mod_c[afr_pkg::MOD_TRIM_BIT] = |trim_vec;
        pack_c = afr_pkg::PACK_RST;
        for (int k = 0; k < afr_pkg::NUM_CH; k++) begin
            if (!float_mode) begin
                pack_c[afr_pkg::PACK_LOW_TOP - 2 * k] = low_vec[k];
                pack_c[afr_pkg::PACK_HIGH_TOP - 2 * k] = high_vec[k];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Live words every cycle; snapshot and strobe on each transfer.
    always_comb begin
        s_d = s_q;
        s_d.live.module_summary_word = mod_c;
        s_d.live.channel_summary_word = sum_c;
        s_d.live.packed_range_condition_word = pack_c;
        s_d.live.channel_condition_word = cond_vec;
        s_d.xfer_valid = 1'b0;
        unique case (s_q.state)
            afr_pkg::AFR_ST_IDLE: begin
                if (xfer_req) begin
                    s_d.sent = s_q.live;
                    s_d.xfer_valid = 1'b1;
                    s_d.state = afr_pkg::AFR_ST_SEND;
                end
            end
            afr_pkg::AFR_ST_SEND: begin
                if (xfer_req) begin
                    s_d.sent = s_q.live;
                    s_d.xfer_valid = 1'b1;
                end else begin
                    s_d.state = afr_pkg::AFR_ST_IDLE;
                end
            end
            default: begin
                s_d.state = afr_pkg::AFR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.state <= afr_pkg::AFR_ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign xfer_valid = s_q.xfer_valid;
    assign xfer_words = s_q.sent;
    assign live_words = s_q.live;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the words that leave the block.
    chk_group_flag_tie: assert property (
        @(posedge ref_clk) disable iff (reset)
        s_q.live.module_summary_word[15]
            == (|s_q.live.channel_summary_word))
        else $error("group flag disagrees with channel summary");

    chk_cal_flag_set: assert property (
        @(posedge ref_clk) disable iff (reset)
        any_cal |=> s_q.live.module_summary_word[10])
        else $error("calibrating flag missing");

    chk_cal_pattern_mask: assert property (
        @(posedge ref_clk) disable iff (reset)
        (any_cal && !link_fault)
            |=> s_q.live.channel_summary_word == $past(used_mask))
        else $error("calibration pattern wrong");

    chk_small_hs_pattern: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!big_variant && wiring == afr_pkg::AFR_WIRE_HS && any_cal
            && !link_fault)
            |=> s_q.live.channel_summary_word == 16'h0003)
        else $error("small variant fast wiring pattern wrong");

    chk_small_se_pattern: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!big_variant && wiring == afr_pkg::AFR_WIRE_SE && any_cal
            && !link_fault)
            |=> s_q.live.channel_summary_word == 16'h00ff)
        else $error("small variant single ended pattern wrong");

    chk_comm_pattern_wins: assert property (
        @(posedge ref_clk) disable iff (reset)
        link_fault |=> s_q.live.channel_summary_word == 16'hffff)
        else $error("link fault pattern missing");

    chk_trim_flag_set: assert property (
        @(posedge ref_clk) disable iff (reset)
        (|trim_vec) |=> s_q.live.module_summary_word[9])
        else $error("trim error summary missing");

    chk_trim_int_mode: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!float_mode && used_mask[0] && chan_in[0].channel_trim_error)
            |=> s_q.live.module_summary_word[9]
                && s_q.live.channel_condition_word[0] == 8'h00)
        else $error("integer mode trim summary wrong");

    chk_nonzero_fault: assert property (
        @(posedge ref_clk) disable iff (reset)
        (link_fault || any_cal || (|trim_vec) || (|(low_vec | high_vec)))
            |=> s_q.live.module_summary_word != 16'h0000)
        else $error("module word zero despite fault");

    chk_low_pack_ch0: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!float_mode && used_mask[0] && chan_in[0].range_low_flag)
            |=> s_q.live.packed_range_condition_word[31])
        else $error("channel 0 low flag not at bit 31");

    chk_high_pack_ch15: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!float_mode && used_mask[15] && chan_in[15].range_high_flag)
            |=> s_q.live.packed_range_condition_word[0])
        else $error("channel 15 high flag not at bit 0");

    chk_pack_float_zero: assert property (
        @(posedge ref_clk) disable iff (reset)
        float_mode |=> s_q.live.packed_range_condition_word == 32'h0)
        else $error("packed word nonzero in float mode");

    chk_range_summary: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!link_fault && !any_cal && used_mask[1]
            && (chan_in[1].range_low_flag || chan_in[1].range_high_flag))
            |=> s_q.live.channel_summary_word[1])
        else $error("range condition missing from summary");

    chk_float_cond_copy: assert property (
        @(posedge ref_clk) disable iff (reset)
        (float_mode && used_mask[2])
            |=> s_q.live.channel_condition_word[2] == $past(chan_in[2]))
        else $error("condition word does not follow channel");

    chk_int_cond_zero: assert property (
        @(posedge ref_clk) disable iff (reset)
        !float_mode |=> s_q.live.channel_condition_word == '0)
        else $error("condition words present in integer mode");

    chk_xfer_snapshot: assert property (
        @(posedge ref_clk) disable iff (reset)
        xfer_req |=> xfer_valid && xfer_words == $past(s_q.live))
        else $error("transfer snapshot wrong");

    chk_xfer_quiet: assert property (
        @(posedge ref_clk) disable iff (reset)
        !xfer_req |=> !xfer_valid)
        else $error("transfer strobe without request");

    chk_low_summary_bit: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!link_fault && !any_cal && used_mask[3] && chan_in[3].range_low_flag)
            |=> s_q.live.channel_summary_word[3])
        else $error("low range missing from summary");

    chk_high_summary_bit: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!link_fault && !any_cal && used_mask[6]
            && chan_in[6].range_high_flag)
            |=> s_q.live.channel_summary_word[6])
        else $error("high range missing from summary");

    chk_trim_float_mode: assert property (
        @(posedge ref_clk) disable iff (reset)
        (float_mode && used_mask[9] && chan_in[9].channel_trim_error)
            |=> s_q.live.channel_condition_word[9][7]
                && s_q.live.module_summary_word[9])
        else $error("channel trim error not summarised");

    chk_mod_unused_zero: assert property (
        @(posedge ref_clk) disable iff (reset)
        s_q.live.module_summary_word[14:11] == 4'h0
            && s_q.live.module_summary_word[8:0] == 9'h000)
        else $error("unused module word bits set");

    chk_small_diff_pattern: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!big_variant && wiring == afr_pkg::AFR_WIRE_DIFF && any_cal
            && !link_fault)
            |=> s_q.live.channel_summary_word == 16'h000f)
        else $error("small variant differential pattern wrong");

    chk_big_se_pattern: assert property (
        @(posedge ref_clk) disable iff (reset)
        (big_variant && wiring == afr_pkg::AFR_WIRE_SE && any_cal
            && !link_fault)
            |=> s_q.live.channel_summary_word == 16'hffff)
        else $error("large variant single ended pattern wrong");

    chk_big_diff_pattern: assert property (
        @(posedge ref_clk) disable iff (reset)
        (big_variant && wiring == afr_pkg::AFR_WIRE_DIFF && any_cal
            && !link_fault)
            |=> s_q.live.channel_summary_word == 16'h00ff)
        else $error("large variant differential pattern wrong");

    chk_cond_bit_order: assert property (
        @(posedge ref_clk) disable iff (reset)
        (float_mode && used_mask[5])
            |=> s_q.live.channel_condition_word[5][7:5]
                == {$past(chan_in[5].channel_trim_error),
                    $past(chan_in[5].range_low_flag),
                    $past(chan_in[5].range_high_flag)})
        else $error("condition word bit order wrong");

    chk_unused_chan_quiet: assert property (
        @(posedge ref_clk) disable iff (reset)
        (!big_variant && !link_fault && !any_cal)
            |=> s_q.live.channel_summary_word[15:8] == 8'h00)
        else $error("unused channel shows in summary");

    chk_xfer_words_hold: assert property (
        @(posedge ref_clk) disable iff (reset)
        !xfer_req |=> $stable(xfer_words))
        else $error("sent words changed without request");

endmodule : afr_fault_report

// File: design/afr_pkg.sv
// Shared constants, codes and carriers of the analog input fault reporting.
package afr_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int NUM_CH = 16;
    localparam int NUM_CH_SMALL = 8;
    localparam int COND_W = 8;
    localparam int SUM_W = 16;
    localparam int PACK_W = 32;

    ////////////////////////////////////////////////////////////////////////
    localparam int COND_TRIM_BIT = 7;
    localparam int COND_LOW_BIT = 6;
    localparam int COND_HIGH_BIT = 5;
    localparam int COND_SLOPE_BIT = 4;
    localparam int COND_LOWER_BIT = 3;
    localparam int COND_UPPER_BIT = 2;
    localparam int COND_LOWLOW_BIT = 1;
    localparam int COND_UPUP_BIT = 0;

    localparam int MOD_GROUP_BIT = 15;
    localparam int MOD_CAL_BIT = 10;
    localparam int MOD_TRIM_BIT = 9;

    localparam int PACK_LOW_TOP = 31;
    localparam int PACK_HIGH_TOP = 30;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [15:0] MASK_BIG_SE = 16'hffff;
    localparam logic [15:0] MASK_BIG_DIFF = 16'h00ff;
    localparam logic [15:0] MASK_BIG_HS = 16'h000f;
    localparam logic [15:0] MASK_SMALL_SE = 16'h00ff;
    localparam logic [15:0] MASK_SMALL_DIFF = 16'h000f;
    localparam logic [15:0] MASK_SMALL_HS = 16'h0003;
    localparam logic [15:0] COMM_FAULT_PATTERN = 16'hffff;

    localparam logic [15:0] SUM_RST = 16'h0000;
    localparam logic [31:0] PACK_RST = 32'h0000_0000;
    localparam logic [7:0] COND_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        AFR_WIRE_SE = 2'h0,
        AFR_WIRE_DIFF = 2'h1,
        AFR_WIRE_HS = 2'h2
    } afr_wiring_e;

    typedef enum logic [1:0] {
        AFR_ST_IDLE = 2'h1,
        AFR_ST_SEND = 2'h2
    } afr_state_e;

    // Per-channel condition inputs, ordered as the condition word bits.
    typedef struct packed {
        logic channel_trim_error;
        logic range_low_flag;
        logic range_high_flag;
        logic slope_limit_flag;
        logic lower_limit_flag;
        logic upper_limit_flag;
        logic lower_lower_limit_flag;
        logic upper_upper_limit_flag;
    } afr_chan_s;

    typedef struct packed {
        logic [15:0] module_summary_word;
        logic [15:0] channel_summary_word;
        logic [31:0] packed_range_condition_word;
        logic [15:0][7:0] channel_condition_word;
    } afr_words_s;

    typedef struct packed {
        afr_state_e state;
        afr_words_s live;
        afr_words_s sent;
        logic xfer_valid;
    } afr_state_s;

endpackage : afr_pkg
